/* logic/sci_target.v */
// Strap capture, clock-mode decode and control-bus target.
`timescale 1ns/100ps
`default_nettype none
`include "sci_defs.vh"
module sci_target (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       clkEn,
	input  wire       powerdownReleasePin,
	input  wire [7:0] modeStrapRatio,
	input  wire [7:0] addressStrapRatio,
	input  wire       modeOverrideEn,
	input  wire [2:0] modeOverrideValue,
	input  wire [1:0] requestedFormat,
	input  wire       sclIn,
	input  wire       sdaIn,
	output wire       sdaOut,
	output wire       sdaOeN,
	output reg        addressStrapPinOut,
	output reg        addressStrapPinOeN,
	output reg        strapCaptured,
	output reg        strapUndefined,
	output reg  [2:0] strappedMode,
	output reg  [2:0] activeMode,
	output reg  [1:0] fwdRefSel,
	output reg        parallelCompatMode,
	output reg        formatSupported,
	output reg  [6:0] targetAddr,
	output reg        io3v3,
	output reg  [7:0] wrData,
	output reg        wrStrobe,
	input  wire [7:0] rdData,
	output reg        rdStrobe,
	output reg        busBusy
);
	localparam ST_IDLE   = 3'h0;
	localparam ST_ADDR   = 3'h1;
	localparam ST_AACK   = 3'h2;
	localparam ST_WBYTE  = 3'h3;
	localparam ST_WACK   = 3'h4;
	localparam ST_RBYTE  = 3'h5;
	localparam ST_RACK   = 3'h6;
	localparam ST_IGNORE = 3'h7;

	////////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for every pin and strap sample.

	wire       pdSync;
	wire       sclSync;
	wire       sdaSync;
	wire [7:0] modeSync;
	wire [7:0] addrSync;

	sci_sync #(.WIDTH(19)) uSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clkEn   (clkEn),
		.asyncIn ({powerdownReleasePin, sclIn, sdaIn, modeStrapRatio, addressStrapRatio}),
		.syncOut ({pdSync, sclSync, sdaSync, modeSync, addrSync})
	);

	reg pdPrev;
	reg sclPrev;
	reg sdaPrev;

	wire pdRise    = pdSync & ~pdPrev;
	wire sclRise   = sclSync & ~sclPrev;
	wire sclFall   = ~sclSync & sclPrev;
	wire startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
	wire stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

	////////////////////////////////////////////////////////////////////////////////////
	// Strap decode.

	reg [2:0] next_mode;
	reg       modeBad;
	reg [1:0] next_addrSel;
	reg       addrBad;

	always @* begin
		modeBad = 1'b0;
		if (modeSync <= `SCI_MODE0_MAX)
			next_mode = `SCI_MODE_SYNC;
		else if (modeSync >= `SCI_MODE2_MIN && modeSync <= `SCI_MODE2_MAX)
			next_mode = `SCI_MODE_EXT;
		else if (modeSync >= `SCI_MODE3_MIN && modeSync <= `SCI_MODE3_MAX)
			next_mode = `SCI_MODE_AON;
		else if (modeSync >= `SCI_MODE5_MIN && modeSync <= `SCI_MODE5_MAX)
			next_mode = `SCI_MODE_PAR;
		else begin
			next_mode = `SCI_MODE_SYNC;
			modeBad   = 1'b1;
		end
	end

	// Setting index 0..3 stands for settings 1..4.
	always @* begin
		addrBad = 1'b0;
		if (addrSync <= `SCI_ADDR1_MAX)
			next_addrSel = 2'h0;
		else if (addrSync >= `SCI_ADDR2_MIN && addrSync <= `SCI_ADDR2_MAX)
			next_addrSel = 2'h1;
		else if (addrSync >= `SCI_ADDR3_MIN && addrSync <= `SCI_ADDR3_MAX)
			next_addrSel = 2'h2;
		else if (addrSync >= `SCI_ADDR4_MIN && addrSync <= `SCI_ADDR4_MAX)
			next_addrSel = 2'h3;
		else begin
			next_addrSel = 2'h0;
			addrBad      = 1'b1;
		end
	end

	// The straps are caught only on the release edge, while the pin still reads the divider.
	always @(posedge ref_clk) begin
		if (rst) begin
			pdPrev         <= 1'b0;
			strapCaptured  <= 1'b0;
			strapUndefined <= 1'b0;
			strappedMode   <= `SCI_MODE_SYNC;
			targetAddr     <= `SCI_ADDR_LOW;
			io3v3          <= 1'b0;
		end else if (clkEn) begin
			pdPrev <= pdSync;
			if (!pdSync) begin
				strapCaptured <= 1'b0;
			end else if (pdRise) begin
				strapCaptured  <= 1'b1;
				strappedMode   <= next_mode;
				strapUndefined <= modeBad | addrBad;
				targetAddr     <= next_addrSel[0] ? `SCI_ADDR_HIGH : `SCI_ADDR_LOW;
				io3v3          <= next_addrSel[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Active mode and clocking selects.

	wire [2:0] next_activeMode = modeOverrideEn ? modeOverrideValue : strappedMode;

	always @(posedge ref_clk) begin
		if (rst) begin
			activeMode         <= `SCI_MODE_SYNC;
			fwdRefSel          <= `SCI_REF_RECOVERED;
			parallelCompatMode <= 1'b0;
			formatSupported    <= 1'b1;
		end else if (clkEn) begin
			activeMode <= next_activeMode;
			case (activeMode)
				`SCI_MODE_EXT: begin
					fwdRefSel          <= `SCI_REF_EXTERNAL;
					parallelCompatMode <= 1'b0;
				end
				`SCI_MODE_AON: begin
					fwdRefSel          <= `SCI_REF_OSCILLATOR;
					parallelCompatMode <= 1'b0;
				end
				`SCI_MODE_PAR: begin
					fwdRefSel          <= `SCI_REF_EXTERNAL;
					parallelCompatMode <= 1'b1;
				end
				default: begin
					fwdRefSel          <= `SCI_REF_RECOVERED;
					parallelCompatMode <= 1'b0;
				end
			endcase
			formatSupported <= !(activeMode == `SCI_MODE_PAR &&
				requestedFormat == `SCI_FMT_LOW_FREQ_12);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Sensor reference clock on the address strap pin.

	reg [3:0] clkDiv;

	always @(posedge ref_clk) begin
		if (rst) begin
			clkDiv             <= 4'h0;
			addressStrapPinOut <= 1'b0;
			addressStrapPinOeN <= 1'b1;
		end else if (clkEn) begin
			// The coming mode is checked as well, so the pin never drives for the one cycle
			// in which activeMode still lags a change into oscillator mode.
			if (strapCaptured && activeMode != `SCI_MODE_AON &&
				next_activeMode != `SCI_MODE_AON) begin
				addressStrapPinOeN <= 1'b0;
				if (clkDiv == `SCI_CLKOUT_HALF) begin
					clkDiv             <= 4'h0;
					addressStrapPinOut <= ~addressStrapPinOut;
				end else begin
					clkDiv <= clkDiv + 4'h1;
				end
			end else begin
				addressStrapPinOeN <= 1'b1;
				addressStrapPinOut <= 1'b0;
				clkDiv             <= 4'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Control-bus target. SCL is never held low, so no stretching occurs here.

	reg [2:0] state;
	reg [3:0] bitCnt;
	reg [7:0] shiftReg;
	reg       sdaDriveLow;
	reg       isRead;
	reg       masterAck;

	// Only low is ever driven; the high level comes from the pull-up.
	assign sdaOut = 1'b0;
	assign sdaOeN = ~sdaDriveLow;

	always @(posedge ref_clk) begin
		if (rst) begin
			sclPrev     <= 1'b1;
			sdaPrev     <= 1'b1;
			state       <= ST_IDLE;
			bitCnt      <= 4'h0;
			shiftReg    <= 8'h00;
			sdaDriveLow <= 1'b0;
			isRead      <= 1'b0;
			masterAck   <= 1'b0;
			wrData      <= 8'h00;
			wrStrobe    <= 1'b0;
			rdStrobe    <= 1'b0;
			busBusy     <= 1'b0;
		end else if (clkEn) begin
			sclPrev  <= sclSync;
			sdaPrev  <= sdaSync;
			wrStrobe <= 1'b0;
			rdStrobe <= 1'b0;
			if (!strapCaptured) begin
				state       <= ST_IDLE;
				sdaDriveLow <= 1'b0;
				busBusy     <= 1'b0;
			end else if (startCond) begin
				state       <= ST_ADDR;
				bitCnt      <= 4'h0;
				sdaDriveLow <= 1'b0;
				busBusy     <= 1'b1;
			end else if (stopCond) begin
				state       <= ST_IDLE;
				sdaDriveLow <= 1'b0;
				busBusy     <= 1'b0;
			end else begin
				case (state)
					ST_ADDR, ST_WBYTE: begin
						if (sclRise && bitCnt != 4'h8) begin
							shiftReg <= {shiftReg[6:0], sdaSync};
							bitCnt   <= bitCnt + 4'h1;
						end else if (sclFall && bitCnt == 4'h8) begin
							bitCnt <= 4'h0;
							if (state == ST_WBYTE) begin
								sdaDriveLow <= 1'b1;
								wrData      <= shiftReg;
								wrStrobe    <= 1'b1;
								state       <= ST_WACK;
							end else if (shiftReg[7:1] == targetAddr) begin
								sdaDriveLow <= 1'b1;
								isRead      <= shiftReg[0];
								state       <= ST_AACK;
							end else begin
								state <= ST_IGNORE;
							end
						end
					end
					ST_AACK, ST_WACK: begin
						if (sclFall) begin
							if (state == ST_AACK && isRead) begin
								shiftReg    <= rdData;
								sdaDriveLow <= ~rdData[7];
								rdStrobe    <= 1'b1;
								bitCnt      <= 4'h1;
								state       <= ST_RBYTE;
							end else begin
								sdaDriveLow <= 1'b0;
								bitCnt      <= 4'h0;
								state       <= ST_WBYTE;
							end
						end
					end
					ST_RBYTE: begin
						if (sclFall) begin
							if (bitCnt == 4'h8) begin
								sdaDriveLow <= 1'b0;
								state       <= ST_RACK;
							end else begin
								sdaDriveLow <= ~shiftReg[6];
								shiftReg    <= {shiftReg[6:0], 1'b0};
								bitCnt      <= bitCnt + 4'h1;
							end
						end
					end
					ST_RACK: begin
						if (sclRise) begin
							masterAck <= ~sdaSync;
						end else if (sclFall) begin
							if (masterAck) begin
								shiftReg    <= rdData;
								sdaDriveLow <= ~rdData[7];
								rdStrobe    <= 1'b1;
								bitCnt      <= 4'h1;
								state       <= ST_RBYTE;
							end else begin
								state <= ST_IGNORE;
							end
						end
					end
					ST_IGNORE: begin
						sdaDriveLow <= 1'b0;
					end
					default: begin
						sdaDriveLow <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // sci_target
`default_nettype wire

/* logic/sci_defs.vh */
// Constants for the strap decoder and control-bus target.
`ifndef SCI_DEFS_VH
`define SCI_DEFS_VH

// Clock-mode codes.
`define SCI_MODE_SYNC        3'h0
`define SCI_MODE_EXT         3'h2
`define SCI_MODE_AON         3'h3
`define SCI_MODE_PAR         3'h5

// Forward reference selects.
`define SCI_REF_RECOVERED    2'h0
`define SCI_REF_EXTERNAL     2'h1
`define SCI_REF_OSCILLATOR   2'h2

// Parallel formats requested by the far end.
`define SCI_FMT_TEN_BIT      2'h0
`define SCI_FMT_LOW_FREQ_12  2'h1
`define SCI_FMT_HIGH_FREQ_12 2'h2

// Strap ratio sample is ratio x 256, eight bits.
`define SCI_MODE0_MAX        8'h22
`define SCI_MODE2_MIN        8'h4a
`define SCI_MODE2_MAX        8'h5d
`define SCI_MODE3_MIN        8'h6a
`define SCI_MODE3_MAX        8'h79
`define SCI_MODE5_MIN        8'ha5
`define SCI_MODE5_MAX        8'hb4
`define SCI_ADDR1_MAX        8'h21
`define SCI_ADDR2_MIN        8'h2e
`define SCI_ADDR2_MAX        8'h41
`define SCI_ADDR3_MIN        8'h8a
`define SCI_ADDR3_MAX        8'h97
`define SCI_ADDR4_MIN        8'ha7
`define SCI_ADDR4_MAX        8'hb4

// Target addresses, 7-bit form.
`define SCI_ADDR_LOW         7'h18
`define SCI_ADDR_HIGH        7'h19

// Sensor reference clock half period in ref_clk cycles, less one.
`define SCI_CLKOUT_HALF      4'h1

`endif

/* logic/sci_sync.v */
// Two-flop synchroniser for signals entering the ref_clk domain.
`timescale 1ns/100ps
`default_nettype none
module sci_sync #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk,
	input  wire             rst,
	input  wire             clkEn,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1;

	always @(posedge ref_clk) begin
		if (rst) begin
			stage1  <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else if (clkEn) begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule // sci_sync
`default_nettype wire

/* tb/sci_assertions.sv */
// Concurrent checks on the ports of the strap decoder and bus target.
`timescale 1ns/100ps
`default_nettype none
module sci_assertions (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOeN,
	input wire logic       addressStrapPinOeN,
	input wire logic       strapCaptured,
	input wire logic [2:0] activeMode,
	input wire logic [1:0] fwdRefSel,
	input wire logic       wrStrobe,
	input wire logic [7:0] rdData,
	input wire logic       rdStrobe,
	input wire logic       busBusy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	pull_only_a:
		assert property (sdaOut == 1'b0) else $error("sda driven high");
	pin_late_a:
		assert property (!strapCaptured [*2] |-> addressStrapPinOeN && sdaOeN)
		else $error("pin or bus active before capture");
	aon_off_a:
		assert property (activeMode == 3'h3 |-> addressStrapPinOeN)
		else $error("sensor clock on in oscillator mode");
	ref_sel_a:
		assert property ($stable(activeMode) [*3] |-> fwdRefSel == (activeMode == 3'h3 ?
			2'h2 : (activeMode == 3'h2 || activeMode == 3'h5) ? 2'h1 : 2'h0))
		else $error("wrong reference select");
	wr_ack_a:
		assert property (wrStrobe |-> ##1 !sdaOeN [*4]) else $error("write byte not acked");
	rd_bit_a:
		assert property (rdStrobe |=> sdaOeN == $past(rdData[7], 2))
		else $error("first read bit wrong");
	idle_free_a:
		assert property (!busBusy [*2] |-> sdaOeN) else $error("sda held while idle");
	stop_cond_a:
		assert property ($fell(busBusy) && strapCaptured |-> sclIn && sdaIn)
		else $error("idle without stop");
endmodule // sci_assertions
bind sci_target sci_assertions i_sci_assertions (.ref_clk, .rst, .sclIn, .sdaIn, .sdaOut,
	.sdaOeN, .addressStrapPinOeN, .strapCaptured, .activeMode, .fwdRefSel, .wrStrobe,
	.rdData, .rdStrobe, .busBusy);
`default_nettype wire

/* tb/sci_host_model.sv */
// Bus controller model that drives the target's control bus.
`timescale 1ns/100ps
`default_nettype none
module sci_host_model (
	input  wire logic sdaOeN,
	input  wire logic sdaOut,
	output wire logic sclWire,
	output wire logic sdaWire
);
	logic sclLow = 1'b0;
	logic sdaLow = 1'b0;
	// Open drain: any party pulling low wins, the pull-up gives the high.
	assign sclWire = !sclLow;
	assign sdaWire = !(sdaLow || (!sdaOeN && !sdaOut));
	// One bit takes 400 ns: SCL low for 200 ns, then high for 200 ns.
	task automatic bitIo(input logic tx, output logic rx);
		sclLow = 1'b1;
		#100;
		sdaLow = !tx;
		#100;
		sclLow = 1'b0;
		wait (sclWire);
		#100;
		rx = sdaWire;
		#100;
	endtask
	task automatic start();
		sclLow = 1'b1;
		#200;
		sdaLow = 1'b0;
		#200;
		sclLow = 1'b0;
		#400;
		sdaLow = 1'b1;
		#400;
	endtask
	task automatic stop();
		sclLow = 1'b1;
		#200;
		sdaLow = 1'b1;
		#200;
		sclLow = 1'b0;
		#400;
		sdaLow = 1'b0;
		#400;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
		output logic ackIn);
		for (int i = 7; i >= 0; i--)
			bitIo(tx[i], rx[i]);
		bitIo(ackOut, ackIn);
	endtask
endmodule // sci_host_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the strap decoder and bus target.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic       clkEn = 1'b1;
	logic       powerdownReleasePin = 1'b0;
	logic [7:0] modeStrapRatio = 8'h00;
	logic [7:0] addressStrapRatio = 8'h00;
	logic       modeOverrideEn = 1'b0;
	logic [2:0] modeOverrideValue = 3'h0;
	logic [1:0] requestedFormat = 2'h0;
	logic [7:0] rdData = 8'h00;
	wire        sclWire, sdaWire, sdaOut, sdaOeN, addressStrapPinOut, addressStrapPinOeN;
	wire        strapCaptured, strapUndefined, parallelCompatMode, formatSupported, io3v3;
	wire        wrStrobe, rdStrobe, busBusy;
	wire  [2:0] strappedMode, activeMode;
	wire  [1:0] fwdRefSel;
	wire  [6:0] targetAddr;
	wire  [7:0] wrData;
	logic [7:0] lastWr, got;
	logic       ack, prev;
	int         n_errors = 0, compares = 0, cycles = 0, nWr = 0, nRd = 0;
	always #25 ref_clk = ~ref_clk;
	sci_target i_sci_target (.ref_clk, .rst, .clkEn, .powerdownReleasePin, .modeStrapRatio,
		.addressStrapRatio, .modeOverrideEn, .modeOverrideValue, .requestedFormat,
		.sclIn(sclWire), .sdaIn(sdaWire), .sdaOut, .sdaOeN, .addressStrapPinOut,
		.addressStrapPinOeN, .strapCaptured, .strapUndefined, .strappedMode, .activeMode,
		.fwdRefSel, .parallelCompatMode, .formatSupported, .targetAddr, .io3v3, .wrData,
		.wrStrobe, .rdData, .rdStrobe, .busBusy);
	sci_host_model i_host (.sdaOeN, .sdaOut, .sclWire, .sdaWire);
	task automatic summarize();
		$display("compares %0d, n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, seen);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic capture(input logic [7:0] mr, ar);
		powerdownReleasePin = 1'b0;
		modeStrapRatio = mr;
		addressStrapRatio = ar;
		repeat (6) @(negedge ref_clk);
		powerdownReleasePin = 1'b1;
		repeat (12) @(negedge ref_clk);
	endtask
	task automatic busByte(input logic [7:0] tx, input logic ackOut, expAck, input string what);
		i_host.xfer(tx, ackOut, got, ack);
		check(what, expAck, ack);
	endtask
	task automatic testStraps();
		logic [7:0] mr[7] = '{8'h22, 8'h4a, 8'h79, 8'ha5, 8'hb4, 8'ha8, 8'h30};
		logic [7:0] ar[7] = '{8'h21, 8'h41, 8'h8a, 8'hb4, 8'ha7, 8'h2e, 8'h60};
		int m[7] = '{0, 2, 3, 5, 5, 5, 0};
		int f[7] = '{0, 1, 2, 1, 2, 0, 0};
		int a[7] = '{1, 2, 3, 4, 4, 2, 1};
		int edges;
		for (int i = 0; i < 7; i++) begin
			requestedFormat = f[i];
			capture(mr[i], ar[i]);
			check("straps", {m[i][2:0], m[i] == 3 ? 2'h2 : m[i] == 0 ? 2'h0 : 2'h1,
				m[i] == 5, !(m[i] == 5 && f[i] == 1), a[i][0] ? 7'h18 : 7'h19, a[i] > 2,
				i == 6, m[i] == 3}, {strappedMode, fwdRefSel, parallelCompatMode,
				formatSupported, targetAddr, io3v3, strapUndefined, addressStrapPinOeN});
			edges = 0;
			repeat (16) begin
				prev = addressStrapPinOut;
				@(negedge ref_clk);
				edges += (addressStrapPinOut !== prev);
			end
			check("pin clock edges", m[i] == 3 ? 0 : 8, edges);
		end
		$display("test straps done");
	endtask
	task automatic testOverride();
		logic [2:0] v[3] = '{3'h3, 3'h5, 3'h2};
		clkEn = 1'b0;
		modeOverrideEn = 1'b1;
		modeOverrideValue = 3'h5;
		repeat (8) @(negedge ref_clk);
		check("frozen mode", 3'h0, activeMode);
		clkEn = 1'b1;
		foreach (v[i]) begin
			modeOverrideEn = 1'b1;
			modeOverrideValue = v[i];
			repeat (8) @(negedge ref_clk);
			check("override", {v[i], v[i] == 3'h3 ? 2'h2 : 2'h1, v[i] == 3'h3},
				{activeMode, fwdRefSel, addressStrapPinOeN});
		end
		modeOverrideEn = 1'b0;
		repeat (8) @(negedge ref_clk);
		check("strap mode back", 5'h00, {activeMode, fwdRefSel});
		$display("test override done");
	endtask
	task automatic testWrite();
		capture(8'h10, 8'h38);
		nWr = 0;
		i_host.start();
		busByte(8'h32, 1'b1, 1'b0, "address ack");
		busByte(8'ha5, 1'b1, 1'b0, "write ack");
		check("write data", 8'ha5, lastWr);
		busByte(8'h3c, 1'b1, 1'b0, "write ack");
		check("write data", 8'h3c, lastWr);
		i_host.stop();
		check("busy after stop", 1'b0, busBusy);
		check("write strobes", 2, nWr);
		$display("test write done");
	endtask
	task automatic testRefuse();
		nWr = 0;
		busByte(8'h32, 1'b1, 1'b1, "ack without start");
		i_host.start();
		busByte(8'h30, 1'b1, 1'b1, "other address");
		busByte(8'h00, 1'b1, 1'b1, "ignored byte");
		i_host.start();
		busByte(8'h32, 1'b1, 1'b0, "repeated start ack");
		i_host.stop();
		check("ignored strobes", 0, nWr);
		$display("test refuse done");
	endtask
	task automatic testRead();
		nRd = 0;
		rdData = 8'h9d;
		i_host.start();
		busByte(8'h33, 1'b1, 1'b0, "read address ack");
		busByte(8'hff, 1'b0, 1'b0, "master ack");
		check("read byte", 8'h9d, got);
		@(negedge ref_clk);
		rdData = 8'h62;
		busByte(8'hff, 1'b1, 1'b1, "master nack");
		check("read byte", 8'h62, got);
		i_host.stop();
		check("read strobes", 2, nRd);
		check("sda released", 1'b1, sdaWire);
		$display("test read done");
	endtask
	// Strobes are counted mid-cycle, away from the edge that launches them.
	always @(negedge ref_clk) begin
		cycles++;
		nRd += (rdStrobe === 1'b1);
		if (wrStrobe === 1'b1) begin
			nWr++;
			lastWr = wrData;
		end
		// The whole run needs about 1195 cycles; the ceiling leaves about three and a third times that.
		if (cycles == 4000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		testStraps();
		testOverride();
		testWrite();
		testRefuse();
		testRead();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
